// ===== hw/spsr_pkg.sv
package spsr_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_STATUS   = 12'h00C;
  localparam logic [11:0] OFS_PRESCALE = 12'h010;
  localparam logic [11:0] OFS_MASK     = 12'h014;
  localparam logic [11:0] OFS_RAW      = 12'h018;
  localparam logic [11:0] OFS_MASKED   = 12'h01C;
  localparam logic [11:0] OFS_CLEAR    = 12'h020;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int ST_ACTIVE  = 4;
  localparam int ST_RX_FULL = 3;
  localparam int ST_RX_NE   = 2;
  localparam int ST_TX_ROOM = 1;
  localparam int ST_TX_EMP  = 0;
  localparam int ST_W       = 5;
  localparam logic [4:0] ST_RESET = 5'h03;

  // ----------------------------------------------------------------
  // interrupt source positions, shared by mask, raw, masked, clear
  // ----------------------------------------------------------------
  localparam int IRQ_TX_SVC  = 3;
  localparam int IRQ_RX_SVC  = 2;
  localparam int IRQ_RX_TO   = 1;
  localparam int IRQ_RX_OVF  = 0;
  localparam int IRQ_W       = 4;
  localparam logic [3:0] RAW_RESET  = 4'h8;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // ----------------------------------------------------------------
  // prescale divisor
  // ----------------------------------------------------------------
  localparam int PRE_W = 8;
  localparam logic [7:0] PRE_RESET = 8'h00;
  localparam logic [7:0] PRE_MIN   = 8'h02;

endpackage : spsr_pkg

// ===== hw/spsr_prescale.sv
`timescale 1ns/1ps

module spsr_prescale #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // divisor from the prescale register
  input  wire logic [W-1:0] prescale_divisor,
  // divided clock outputs
  output logic              prescale_tick_r,
  output logic              serial_bit_clock_r
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         tick_nxt;
  logic         clk_nxt;
  logic [W-1:0] half;

  // ----------------------------------------------------------------
  // divide by the even divisor, half a period per phase
  // ----------------------------------------------------------------
  always_comb begin
    half      = prescale_divisor >> 1;
    count_nxt = count_r;
    tick_nxt  = 1'b0;
    clk_nxt   = serial_bit_clock_r;
    if (prescale_divisor < spsr_pkg::PRE_MIN) begin
      count_nxt = '0;        // stopped while divisor below two
      clk_nxt   = 1'b0;
    end else if (count_r >= half - W'(1)) begin
      count_nxt = '0;
      clk_nxt   = ~serial_bit_clock_r;
      tick_nxt  = ~serial_bit_clock_r; // one pulse per full period
    end else begin
      count_nxt = count_r + W'(1);
    end
  end

  // registers only
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_r            <= '0;
      prescale_tick_r    <= 1'b0;
      serial_bit_clock_r <= 1'b0;
    end else begin
      count_r            <= count_nxt;
      prescale_tick_r    <= tick_nxt;
      serial_bit_clock_r <= clk_nxt;
    end
  end

endmodule : spsr_prescale

// ===== hw/spsr_regs.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps

module spsr_regs #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // fifo and shifter state from the port
  input  wire logic              tx_fifo_empty,
  input  wire logic              tx_fifo_full,
  input  wire logic              rx_fifo_empty,
  input  wire logic              rx_fifo_full,
  input  wire logic              shifter_busy,
  // interrupt conditions from the port
  input  wire logic              tx_half_empty,
  input  wire logic              rx_service_cond,
  input  wire logic              rx_timeout_evt,
  input  wire logic              rx_overflow_evt,
  // outputs to the port and the system
  output logic [4:0]             status_flags,
  output logic [7:0]             prescale_divisor,
  output logic                   prescale_tick,
  output logic                   serial_bit_clock,
  output logic                   port_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // state registers and their next values
  logic [4:0]  status_r;
  logic [4:0]  status_nxt;
  logic [3:0]  raw_r;
  logic [3:0]  raw_nxt;
  logic [3:0]  mask_r;
  logic [3:0]  mask_nxt;
  logic [7:0]  pre_r;
  logic [7:0]  pre_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  // bus decode
  logic        access;
  logic        wr_fire;
  logic        wr_pre;
  logic        wr_mask;
  logic        wr_clr;
  logic        sel_status;
  logic        sel_pre;
  logic        sel_mask;
  logic        sel_raw;
  logic        sel_masked;
  logic        sel_clear;
  logic [31:0] rd_word;
  // interrupt views
  logic [3:0]  masked;
  logic [3:0]  clr_req;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // word match of the bus address against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0]       ofs);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2));
  endfunction : hit

  // true when the address names any register of this block
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, spsr_pkg::OFS_STATUS)
           | hit(a, spsr_pkg::OFS_PRESCALE)
           | hit(a, spsr_pkg::OFS_MASK)
           | hit(a, spsr_pkg::OFS_RAW)
           | hit(a, spsr_pkg::OFS_MASKED)
           | hit(a, spsr_pkg::OFS_CLEAR);
  endfunction : mapped

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------

  // sample fifo and shifter state every cycle
  always_comb begin
    status_nxt = '0;
    status_nxt[spsr_pkg::ST_ACTIVE]  = shifter_busy
                                     | ~tx_fifo_empty;
    status_nxt[spsr_pkg::ST_RX_FULL] = rx_fifo_full;
    status_nxt[spsr_pkg::ST_RX_NE]   = ~rx_fifo_empty;
    status_nxt[spsr_pkg::ST_TX_ROOM] = ~tx_fifo_full;
    status_nxt[spsr_pkg::ST_TX_EMP]  = tx_fifo_empty;
  end

  // status register, reset shows idle and empty fifos
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= spsr_pkg::ST_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // apb access decode
  // ----------------------------------------------------------------

  // one select per register, from the word address
  always_comb begin
    sel_status = hit(paddr, spsr_pkg::OFS_STATUS);
    sel_pre    = hit(paddr, spsr_pkg::OFS_PRESCALE);
    sel_mask   = hit(paddr, spsr_pkg::OFS_MASK);
    sel_raw    = hit(paddr, spsr_pkg::OFS_RAW);
    sel_masked = hit(paddr, spsr_pkg::OFS_MASKED);
    sel_clear  = hit(paddr, spsr_pkg::OFS_CLEAR);
  end

  // access phase and the edge on which a write lands
  assign access  = psel & penable;
  assign wr_fire = access & pready_r & pwrite;

  // write strobes per register, only where pready is seen high
  assign wr_pre  = wr_fire & sel_pre;
  assign wr_mask = wr_fire & sel_mask;
  assign wr_clr  = wr_fire & sel_clear;

  // clear strobes from the interrupt clear register
  always_comb begin
    clr_req = '0;
    if (wr_clr) begin
      clr_req[spsr_pkg::IRQ_RX_TO]  = pwdata[spsr_pkg::IRQ_RX_TO];
      clr_req[spsr_pkg::IRQ_RX_OVF] = pwdata[spsr_pkg::IRQ_RX_OVF];
    end
  end

  // ----------------------------------------------------------------
  // software registers: prescale and mask
  // ----------------------------------------------------------------

  // write decode, bit 0 of the divisor never stored
  always_comb begin
    pre_nxt  = pre_r;
    mask_nxt = mask_r;
    if (wr_pre) begin
      pre_nxt = {pwdata[7:1], 1'b0};
    end
    if (wr_mask) begin
      mask_nxt = pwdata[3:0];
    end
  end

  // software registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_r  <= spsr_pkg::PRE_RESET;
      mask_r <= spsr_pkg::MASK_RESET;
    end else begin
      pre_r  <= pre_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // raw interrupt status
  // ----------------------------------------------------------------

  // levels follow the fifo, events stick until cleared
  always_comb begin
    raw_nxt = raw_r;
    // service levels copied every cycle
    raw_nxt[spsr_pkg::IRQ_TX_SVC] = tx_half_empty;
    raw_nxt[spsr_pkg::IRQ_RX_SVC] = rx_service_cond;
    // time-out flag: clear first, so a new event in the same cycle wins
    if (clr_req[spsr_pkg::IRQ_RX_TO]) begin
      raw_nxt[spsr_pkg::IRQ_RX_TO] = 1'b0;
    end
    if (rx_timeout_evt) begin
      raw_nxt[spsr_pkg::IRQ_RX_TO] = 1'b1;
    end
    // overrun flag, same priority
    if (clr_req[spsr_pkg::IRQ_RX_OVF]) begin
      raw_nxt[spsr_pkg::IRQ_RX_OVF] = 1'b0;
    end
    if (rx_overflow_evt) begin
      raw_nxt[spsr_pkg::IRQ_RX_OVF] = 1'b1;
    end
  end

  // raw status register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      raw_r <= spsr_pkg::RAW_RESET;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  // ----------------------------------------------------------------
  // masking and interrupt output
  // ----------------------------------------------------------------

  // masked view of the current raw status
  always_comb begin
    masked = '0;
    masked[spsr_pkg::IRQ_TX_SVC] = raw_r[spsr_pkg::IRQ_TX_SVC]
                                 & mask_r[spsr_pkg::IRQ_TX_SVC];
    masked[spsr_pkg::IRQ_RX_SVC] = raw_r[spsr_pkg::IRQ_RX_SVC]
                                 & mask_r[spsr_pkg::IRQ_RX_SVC];
    masked[spsr_pkg::IRQ_RX_TO]  = raw_r[spsr_pkg::IRQ_RX_TO]
                                 & mask_r[spsr_pkg::IRQ_RX_TO];
    masked[spsr_pkg::IRQ_RX_OVF] = raw_r[spsr_pkg::IRQ_RX_OVF]
                                 & mask_r[spsr_pkg::IRQ_RX_OVF];
  end

  // interrupt line from next raw and mask values
  always_comb begin
    irq_nxt = |(raw_nxt & mask_nxt);
  end

  // interrupt register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: one wait state, data and error registered
  // ----------------------------------------------------------------

  // read mux, reserved bits zero, clear register reads zero
  always_comb begin
    rd_word = '0;
    if (sel_status) begin
      rd_word[4:0] = status_r;
    end
    if (sel_pre) begin
      rd_word[7:0] = pre_r;
    end
    if (sel_mask) begin
      rd_word[3:0] = mask_r;
    end
    if (sel_raw) begin
      rd_word[3:0] = raw_r;
    end
    if (sel_masked) begin
      rd_word[3:0] = masked;
    end
  end

  // answer one cycle into the access phase, data only for reads
  always_comb begin
    pready_nxt  = access & ~pready_r;
    prdata_nxt  = '0;
    pslverr_nxt = 1'b0;
    if (access && !pready_r) begin
      pslverr_nxt = ~mapped(paddr);
      if (!pwrite) begin
        prdata_nxt = rd_word;
      end
    end
  end

  // bus answer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // clock prescaler
  // ----------------------------------------------------------------

  // divides the system clock by the stored divisor
  spsr_prescale #(
    .W (spsr_pkg::PRE_W)
  ) u_prescale (
    .clock              (clock),
    .rst_b              (rst_b),
    .prescale_divisor   (pre_r),
    .prescale_tick_r    (prescale_tick),
    .serial_bit_clock_r (serial_bit_clock)
  );

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  // bus answer and state copies, no logic after the flops
  assign pready           = pready_r;
  assign prdata           = prdata_r;
  assign pslverr          = pslverr_r;
  assign status_flags     = status_r;
  assign prescale_divisor = pre_r;
  assign port_irq         = irq_r;

endmodule : spsr_regs

// ===== sim/spsr_regs_sva.sv
`timescale 1ns/1ps

module spsr_regs_sva #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              rst_b,
  // apb slave side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // port state
  input wire logic              tx_fifo_empty,
  input wire logic              tx_fifo_full,
  input wire logic              rx_fifo_empty,
  input wire logic              rx_fifo_full,
  input wire logic              shifter_busy,
  // outputs
  input wire logic [4:0]        status_flags,
  input wire logic [7:0]        prescale_divisor,
  input wire logic              serial_bit_clock,
  input wire logic              prescale_tick
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_status_map: assert property ($past(rst_b) |-> status_flags ==
    {$past(shifter_busy | ~tx_fifo_empty), $past(rx_fifo_full), $past(~rx_fifo_empty),
     $past(~tx_fifo_full), $past(tx_fifo_empty)})
    else $error("status flags do not follow port state");
  a_div_lsb: assert property (prescale_divisor[0] == 1'b0)
    else $error("divisor bit 0 set");
  a_clk_stop: assert property (prescale_divisor < 8'h02 && $past(prescale_divisor) < 8'h02
    && $past(prescale_divisor, 2) < 8'h02 |-> !serial_bit_clock)
    else $error("serial clock runs with divisor below two");
  a_clk_period: assert property ($rose(serial_bit_clock) && prescale_divisor == 8'h04
    ##1 (prescale_divisor == 8'h04)[*4] |-> $rose(serial_bit_clock))
    else $error("serial clock period not four cycles");
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not at second edge after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (pready |->
    pslverr == (paddr[ADDR_W-1:2] < 3 || paddr[ADDR_W-1:2] > 8))
    else $error("error response does not match decode");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error outside answer");
  a_tick_rise: assert property (prescale_tick == $rose(serial_bit_clock))
    else $error("tick not on rising serial clock");
endmodule : spsr_regs_sva

bind spsr_regs spsr_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
  .clock            (clock),
  .rst_b            (rst_b),
  .psel             (psel),
  .penable          (penable),
  .paddr            (paddr),
  .pready           (pready),
  .prdata           (prdata),
  .pslverr          (pslverr),
  .tx_fifo_empty    (tx_fifo_empty),
  .tx_fifo_full     (tx_fifo_full),
  .rx_fifo_empty    (rx_fifo_empty),
  .rx_fifo_full     (rx_fifo_full),
  .shifter_busy     (shifter_busy),
  .status_flags     (status_flags),
  .prescale_divisor (prescale_divisor),
  .serial_bit_clock (serial_bit_clock),
  .prescale_tick    (prescale_tick)
);

// ===== sim/spsr_regs_tb.sv
`timescale 1ns/1ps

module spsr_regs_tb;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, port_irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        tx_fifo_empty, tx_fifo_full, rx_fifo_empty, rx_fifo_full, shifter_busy;
  logic        tx_half_empty, rx_service_cond, rx_timeout_evt, rx_overflow_evt;
  logic        prescale_tick, serial_bit_clock;
  logic [4:0]  status_flags;
  logic [7:0]  prescale_divisor;
  int          bad_count, samples_checked, cycles, mask_m, to_m, ovf_m, t_cnt, h_cnt;
  int          pre_tab[5] = '{1, 2, 7, 254, 255};

  spsr_regs dut (
    .clock            (clock),
    .rst_b            (rst_b),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pready           (pready),
    .prdata           (prdata),
    .pslverr          (pslverr),
    .tx_fifo_empty    (tx_fifo_empty),
    .tx_fifo_full     (tx_fifo_full),
    .rx_fifo_empty    (rx_fifo_empty),
    .rx_fifo_full     (rx_fifo_full),
    .shifter_busy     (shifter_busy),
    .tx_half_empty    (tx_half_empty),
    .rx_service_cond  (rx_service_cond),
    .rx_timeout_evt   (rx_timeout_evt),
    .rx_overflow_evt  (rx_overflow_evt),
    .status_flags     (status_flags),
    .prescale_divisor (prescale_divisor),
    .prescale_tick    (prescale_tick),
    .serial_bit_clock (serial_bit_clock),
    .port_irq         (port_irq)
  );

  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] st_exp();
    return {27'h0, shifter_busy | ~tx_fifo_empty, rx_fifo_full, ~rx_fifo_empty,
            ~tx_fifo_full, tx_fifo_empty};
  endfunction : st_exp
  function automatic logic [31:0] raw_exp();
    return {28'h0, tx_half_empty, rx_service_cond, 1'(to_m), 1'(ovf_m)};
  endfunction : raw_exp
  task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask : check
  // one apb transfer, held until ready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, rd, e);
    check({w, " err"}, {31'h0, er}, 32'h0);
  endtask : rchk
  task automatic set_levels(input logic [31:0] r);
    @(posedge clock);
    tx_fifo_empty   <= r[0];
    tx_fifo_full    <= r[1] & ~r[0];
    rx_fifo_empty   <= r[2];
    rx_fifo_full    <= r[3] & ~r[2];
    shifter_busy    <= r[4];
    tx_half_empty   <= r[5];
    rx_service_cond <= r[6];
    @(negedge clock);
  endtask : set_levels
  task automatic pulse(input logic t, input logic o);
    @(posedge clock);
    rx_timeout_evt  <= t;
    rx_overflow_evt <= o;
    @(posedge clock);
    rx_timeout_evt  <= 1'b0;
    rx_overflow_evt <= 1'b0;
    to_m  = to_m | t;
    ovf_m = ovf_m | o;
  endtask : pulse
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, rx_timeout_evt, rx_overflow_evt, tx_fifo_full} = '0;
    {rx_fifo_full, shifter_busy, rx_service_cond} = '0;
    {tx_fifo_empty, rx_fifo_empty, tx_half_empty} = '1;
    paddr  = '0;
    pwdata = '0;
    seed   = 32'h7892E930;
    rst_b  = 1'b0;
    repeat (20) @(posedge clock);
    check("reset flags", {27'h0, status_flags}, 32'h3);
    rst_b <= 1'b1;
    rchk("status", spsr_pkg::OFS_STATUS, 32'h3);
    rchk("prescale", spsr_pkg::OFS_PRESCALE, 32'h0);
    rchk("mask", spsr_pkg::OFS_MASK, 32'h0);
    rchk("raw", spsr_pkg::OFS_RAW, 32'h8);
    rchk("masked", spsr_pkg::OFS_MASKED, 32'h0);
    $display("reset test done");
    // random port state
    repeat (12) begin
      seed = lfsr(seed);
      set_levels(seed);
      rchk("status", spsr_pkg::OFS_STATUS, st_exp());
      check("flags", {27'h0, status_flags}, st_exp());
      rchk("raw", spsr_pkg::OFS_RAW, raw_exp());
    end
    $display("status test done");
    foreach (pre_tab[i]) begin
      apb(1'b1, spsr_pkg::OFS_PRESCALE, {24'hFFFFFF, 8'(pre_tab[i])});
      rchk("prescale", spsr_pkg::OFS_PRESCALE, pre_tab[i] & 254);
      check("divisor", {24'h0, prescale_divisor}, pre_tab[i] & 254);
    end
    $display("prescale test done");
    // every mask value with random sources and clears
    for (int m = 0; m < 16; m++) begin
      seed = lfsr(seed);
      apb(1'b1, spsr_pkg::OFS_MASK, {seed[31:4], 4'(m)});
      mask_m = m;
      pulse(seed[0], seed[1]);
      set_levels(seed >> 8);
      rchk("mask", spsr_pkg::OFS_MASK, mask_m);
      rchk("raw", spsr_pkg::OFS_RAW, raw_exp());
      rchk("masked", spsr_pkg::OFS_MASKED, raw_exp() & mask_m);
      check("irq", {31'h0, port_irq}, {31'h0, |(raw_exp() & mask_m)});
      apb(1'b1, spsr_pkg::OFS_CLEAR, {30'h0, seed[2], seed[3]});
      to_m  = to_m & ~seed[2];
      ovf_m = ovf_m & ~seed[3];
    end
    // event and clear landing on one edge: the event wins
    fork
      apb(1'b1, spsr_pkg::OFS_CLEAR, 32'h3);
      begin
        repeat (3) @(posedge clock);
        rx_timeout_evt  <= 1'b1;
        rx_overflow_evt <= 1'b1;
        @(posedge clock);
        rx_timeout_evt  <= 1'b0;
        rx_overflow_evt <= 1'b0;
      end
    join
    to_m  = 1;
    ovf_m = 1;
    rchk("set wins", spsr_pkg::OFS_RAW, raw_exp());
    check("irq held", {31'h0, port_irq}, {31'h0, |(raw_exp() & mask_m)});
    apb(1'b1, spsr_pkg::OFS_CLEAR, 32'h3);
    to_m  = 0;
    ovf_m = 0;
    rchk("cleared", spsr_pkg::OFS_RAW, raw_exp());
    apb(1'b1, spsr_pkg::OFS_RAW, 32'hFFFFFFFF);
    apb(1'b1, spsr_pkg::OFS_MASKED, 32'h0);
    rchk("raw kept", spsr_pkg::OFS_RAW, raw_exp());
    rchk("clear reads", spsr_pkg::OFS_CLEAR, 32'h0);
    $display("interrupt test done");
    // unmapped places
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    check("unmapped write err", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("unmapped read err", {31'h0, er}, 32'h1);
    rchk("mask kept", spsr_pkg::OFS_MASK, mask_m);
    $display("decode test done");
    // divided clock with a legal divisor
    apb(1'b1, spsr_pkg::OFS_PRESCALE, 32'h4);
    repeat (8) @(posedge clock);
    t_cnt = 0;
    h_cnt = 0;
    repeat (40) begin
      @(negedge clock);
      t_cnt += int'(prescale_tick === 1'b1);
      h_cnt += int'(serial_bit_clock === 1'b1);
    end
    check("ticks", t_cnt, 10);
    check("clock high", h_cnt, 20);
    $display("clock test done");
    conclude();
  end
endmodule : spsr_regs_tb
